// ===== rtl/bt3_pkg.sv
package bt3_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] VOLTAGE_SELECT_ADDR = 8'h30;
    localparam logic [7:0] MODE_SELECT_ADDR = 8'h31;
    localparam logic [7:0] SPARE_READONLY_ADDR = 8'h32;
    localparam logic [7:0] ENABLE_AND_STATUS_ADDR = 8'h33;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CODE_LSB = 0; // voltage code [5:0]
    localparam int CODE_W = 6;
    localparam int RANGE_BIT = 6; // range select
    localparam int MODE_BIT = 0; // 1 = forced fixed frequency
    localparam int ENABLE_BIT = 0; // converter enable
    localparam int PGOOD_BIT = 1; // power-good, read only
    localparam int EXACT_BIT = 2; // write-exact bit

    // ------------------------------------------------------------
    // reset values (plain defaults)
    // ------------------------------------------------------------
    localparam logic [5:0] CODE_RST = 6'h00;
    localparam logic RANGE_RST = 1'b1;
    localparam logic MODE_RST = 1'b0;
    localparam logic ENABLE_RST = 1'b1;
    localparam logic EXACT_RST = 1'b0;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ------------------------------------------------------------
    // timing: switching oscillator derived from the 200 MHz clock
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000; // 5 ns
    localparam int OSC_PERIOD_PS = 625000; // 1.6 MHz
    localparam int OSC_CYC = OSC_PERIOD_PS / CLK_PERIOD_PS;
    localparam int DUTY_W = 7;

    // ------------------------------------------------------------
    // voltage map in millivolts
    // ------------------------------------------------------------
    localparam int MV_W = 13;
    localparam int HIGH_BASE_MV = 1250;
    localparam int HIGH_STEP_MV = 50;
    localparam logic [5:0] LOW_FIRST_CODE = 6'h12;
    // low range, indexed by the full code; zero marks an unavailable code
    localparam logic [12:0] LOW_RANGE_MV [64] = '{
        13'd0, 13'd0, 13'd0, 13'd0, 13'd0, 13'd0, 13'd0, 13'd0,
        13'd0, 13'd0, 13'd0, 13'd0, 13'd0, 13'd0, 13'd0, 13'd0,
        13'd0, 13'd0, 13'd1100, 13'd1125, 13'd1150, 13'd1175, 13'd1200, 13'd1225,
        13'd1255, 13'd1280, 13'd1305, 13'd1330, 13'd1355, 13'd1380, 13'd1405, 13'd1430,
        13'd1455, 13'd1480, 13'd1505, 13'd1530, 13'd1555, 13'd1585, 13'd1610, 13'd1635,
        13'd1660, 13'd1685, 13'd1710, 13'd1735, 13'd1760, 13'd1785, 13'd1810, 13'd1835,
        13'd1860, 13'd1890, 13'd1915, 13'd1940, 13'd1965, 13'd1990, 13'd2015, 13'd2040,
        13'd2065, 13'd2090, 13'd2115, 13'd2140, 13'd2165, 13'd2190, 13'd2200, 13'd2245
    };
endpackage

// ===== rtl/bt3_regs.sv
module bt3_regs #(
    parameter logic [5:0] RESET_CODE = bt3_pkg::CODE_RST,
    parameter logic RESET_RANGE = bt3_pkg::RANGE_RST,
    parameter logic RESET_ENABLE = bt3_pkg::ENABLE_RST
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire logic CONVERTER_ENABLE_PIN,
    input wire logic POWER_GOOD_RAW,
    input wire logic LIGHT_LOAD,
    input wire logic [bt3_pkg::DUTY_W-1:0] DUTY_DEMAND,
    output logic [5:0] VOLTAGE_CODE,
    output logic RANGE_SELECT,
    output logic FORCE_FIXED_FREQ,
    output logic [bt3_pkg::MV_W-1:0] TARGET_MV,
    output logic CODE_UNAVAILABLE,
    output logic CONVERTER_RUN,
    output logic OSC_TICK,
    output logic HIGH_SIDE_ON
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [5:0] code_r; // voltage code
    logic range_r; // range select
    logic mode_r; // forced fixed frequency
    logic enable_r; // software enable
    logic exact_r; // write-exact storage
    logic pg_s1_r; // synchroniser first stage
    logic pg_s2_r; // synchroniser second stage
    logic [7:0] osc_cnt_r; // oscillator divider
    logic [7:0] osc_cnt_nxt;
    logic hs_nxt;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire sel_volt = (REG_ADDR == bt3_pkg::VOLTAGE_SELECT_ADDR);
    wire sel_mode = (REG_ADDR == bt3_pkg::MODE_SELECT_ADDR);
    wire sel_ctl = (REG_ADDR == bt3_pkg::ENABLE_AND_STATUS_ADDR);
    wire wr_volt = REG_WR && sel_volt;
    wire wr_mode = REG_WR && sel_mode;
    wire wr_ctl = REG_WR && sel_ctl;

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // only defined fields store; read-only bits drop the write
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            code_r <= RESET_CODE;
            range_r <= RESET_RANGE;
            mode_r <= bt3_pkg::MODE_RST;
            enable_r <= RESET_ENABLE;
            exact_r <= bt3_pkg::EXACT_RST;
        end else begin
            if (wr_volt) begin
                code_r <= REG_WDATA[bt3_pkg::CODE_LSB +: bt3_pkg::CODE_W];
                range_r <= REG_WDATA[bt3_pkg::RANGE_BIT];
            end
            if (wr_mode) begin
                mode_r <= REG_WDATA[bt3_pkg::MODE_BIT];
            end
            if (wr_ctl) begin
                enable_r <= REG_WDATA[bt3_pkg::ENABLE_BIT];
                exact_r <= REG_WDATA[bt3_pkg::EXACT_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // power-good synchroniser
    // ------------------------------------------------------------
    // comparator output is asynchronous to the register clock
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            pg_s1_r <= 1'b0;
            pg_s2_r <= 1'b0;
        end else begin
            pg_s1_r <= POWER_GOOD_RAW;
            pg_s2_r <= pg_s1_r;
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // reserved bits and the spare register read zero
    wire [7:0] rd_volt = {1'b0, range_r, code_r};
    wire [7:0] rd_mode = {7'h00, mode_r};
    wire [7:0] rd_ctl = {5'h00, exact_r, pg_s2_r, enable_r};
    wire [7:0] rd_mux = sel_volt ? rd_volt :
                        sel_mode ? rd_mode :
                        sel_ctl ? rd_ctl : bt3_pkg::READ_ZERO;

    // read data is captured on the read strobe and held
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            REG_RDATA <= bt3_pkg::READ_ZERO;
        end else if (REG_RD) begin
            REG_RDATA <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // voltage map
    // ------------------------------------------------------------
    wire [12:0] high_mv = 13'(bt3_pkg::HIGH_BASE_MV + bt3_pkg::HIGH_STEP_MV * int'(code_r));
    wire [12:0] low_mv = bt3_pkg::LOW_RANGE_MV[code_r];
    wire low_bad = !range_r && (code_r < bt3_pkg::LOW_FIRST_CODE);

    // target follows the code in the selected range
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            TARGET_MV <= '0;
            CODE_UNAVAILABLE <= 1'b0;
        end else begin
            TARGET_MV <= range_r ? high_mv : low_mv;
            CODE_UNAVAILABLE <= low_bad;
        end
    end

    assign VOLTAGE_CODE = code_r;
    assign RANGE_SELECT = range_r;
    assign FORCE_FIXED_FREQ = mode_r;

    // ------------------------------------------------------------
    // enable and switching oscillator
    // ------------------------------------------------------------
    // free-running divider, one tick per switching period
    assign osc_cnt_nxt = (osc_cnt_r == 8'(bt3_pkg::OSC_CYC - 1)) ? 8'h00 : osc_cnt_r + 8'h01;
    // light load without forced mode skips pulses, even at full demand; otherwise full demand stays on
    wire skip = !mode_r && LIGHT_LOAD;
    wire full_duty = (int'(DUTY_DEMAND) >= bt3_pkg::OSC_CYC);
    assign hs_nxt = CONVERTER_RUN && !skip &&
                    (full_duty || (osc_cnt_r < 8'(DUTY_DEMAND)));

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            osc_cnt_r <= 8'h00;
            OSC_TICK <= 1'b0;
            CONVERTER_RUN <= 1'b0;
            HIGH_SIDE_ON <= 1'b0;
        end else begin
            osc_cnt_r <= osc_cnt_nxt;
            OSC_TICK <= (osc_cnt_r == 8'(bt3_pkg::OSC_CYC - 1));
            CONVERTER_RUN <= CONVERTER_ENABLE_PIN && enable_r;
            HIGH_SIDE_ON <= hs_nxt;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    localparam int OSC_CYCLES = bt3_pkg::OSC_CYC;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    sequence s_volt_write;
        REG_WR && REG_ADDR == 8'h30;
    endsequence
    sequence s_ctl_read;
        REG_RD && REG_ADDR == 8'h33;
    endsequence

    chk_code_write: assert property (s_volt_write |=>
        VOLTAGE_CODE == $past(REG_WDATA[5:0]) && RANGE_SELECT == $past(REG_WDATA[6]))
        else $error("voltage code or range not stored");
    chk_high_range_map: assert property (s_volt_write ##0 REG_WDATA[6] |=> ##1
        TARGET_MV == 13'(1250 + 50 * int'($past(REG_WDATA[5:0], 2))))
        else $error("high range voltage wrong");
    chk_low_unavail: assert property (s_volt_write ##0 !REG_WDATA[6]
        ##0 REG_WDATA[5:0] >= 6'h12 |=> ##1 !CODE_UNAVAILABLE && TARGET_MV >= 13'h44C)
        else $error("available low code flagged or mapped too low");
    chk_mode_write: assert property (REG_WR && REG_ADDR == 8'h31 |=>
        FORCE_FIXED_FREQ == $past(REG_WDATA[0]))
        else $error("mode bit not stored");
    chk_pin_gate: assert property (!CONVERTER_ENABLE_PIN |=> !CONVERTER_RUN ##1
        (!HIGH_SIDE_ON || CONVERTER_RUN))
        else $error("converter runs with pin low");
    chk_pgood_sync: assert property (POWER_GOOD_RAW[*3] ##0 s_ctl_read |=>
        REG_RDATA[1])
        else $error("power good not reported");
    chk_pgood_low: assert property ((!POWER_GOOD_RAW)[*3] ##0 s_ctl_read |=>
        !REG_RDATA[1])
        else $error("power good reported while low");
    chk_reserved_zero: assert property (REG_RD |=>
        REG_RDATA[7] == 1'b0 && ($past(REG_ADDR) != 8'h32 || REG_RDATA == 8'h00))
        else $error("reserved bit read nonzero");
    chk_exact_keep: assert property (!(REG_WR && REG_ADDR == 8'h33) |=>
        $stable(exact_r))
        else $error("write-exact bit changed by other write");
    chk_full_duty: assert property (CONVERTER_RUN && FORCE_FIXED_FREQ
        && DUTY_DEMAND >= 7'd125 |=> HIGH_SIDE_ON)
        else $error("full duty did not hold switch on");
    chk_osc_period: assert property (OSC_TICK |-> ##OSC_CYCLES OSC_TICK)
        else $error("oscillator period wrong");
    chk_osc_single: assert property (OSC_TICK |=> !OSC_TICK)
        else $error("oscillator tick too long");
endmodule

// ===== verification/bt3_host_model.sv
// --------------------------------------------------------------
// serial host as seen from the register byte port
// --------------------------------------------------------------
module bt3_host_model (
    input wire logic CLOCK,
    output logic [7:0] REG_ADDR,
    output logic REG_WR,
    output logic [7:0] REG_WDATA,
    output logic REG_RD
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus: strobes low, address parked off the bank
    initial begin
        REG_ADDR = 8'hCF;
        REG_WR = 1'b0;
        REG_WDATA = 8'h00;
        REG_RD = 1'b0;
    end

    // one byte write; the write-exact bit always goes out at its default
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLOCK);
        REG_ADDR = a;
        REG_WDATA = (a == bt3_pkg::ENABLE_AND_STATUS_ADDR) ?
                    {d[7:3], bt3_pkg::EXACT_RST, d[1:0]} : d;
        REG_WR = 1'b1;
        @(negedge CLOCK);
        REG_WR = 1'b0;
        REG_ADDR = ~a;
        REG_WDATA = ~REG_WDATA;
    endtask

    // one byte read; data is picked up by the bench monitor
    task automatic rd(input logic [7:0] a);
        @(negedge CLOCK);
        REG_ADDR = a;
        REG_RD = 1'b1;
        @(negedge CLOCK);
        REG_RD = 1'b0;
        REG_ADDR = ~a;
    endtask
endmodule

// ===== verification/bt3_regs_tb.sv
// --------------------------------------------------------------
// compare helper: counts every compare and each mismatch
// --------------------------------------------------------------
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
    $display("unexpected %s exp %0h got %0h", nm, ex, got); failures++; end end

module bt3_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLOCK = 1'b0;
    logic RST, pin, pg_raw, light;
    logic [6:0] duty;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, e;
    logic reg_wr, reg_rd, rd_d;
    logic [5:0] code;
    logic [12:0] target_mv;
    logic run, osc_tick, high_side, force_ff;
    logic [5:0] vcode; // stored code seen at the field output
    logic rsel, unavail;
    logic [5:0] lo_code [3] = '{6'h12, 6'h2E, 6'h3F};
    logic [12:0] lo_mv [3] = '{13'h44C, 13'h712, 13'h8C5};
    logic [7:0] exp_q [$];
    int failures = 0, cmp_count = 0, cyc = 0, i, t0, n, dummy;

    always #2.5 CLOCK = ~CLOCK;

    bt3_host_model host (.CLOCK(CLOCK), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
        .REG_WDATA(reg_wdata), .REG_RD(reg_rd));

    bt3_regs DUT (.CLOCK(CLOCK), .RST(RST), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
        .REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .CONVERTER_ENABLE_PIN(pin), .POWER_GOOD_RAW(pg_raw), .LIGHT_LOAD(light),
        .DUTY_DEMAND(duty), .VOLTAGE_CODE(vcode), .RANGE_SELECT(rsel),
        .FORCE_FIXED_FREQ(force_ff), .TARGET_MV(target_mv), .CODE_UNAVAILABLE(unavail),
        .CONVERTER_RUN(run),
        .OSC_TICK(osc_tick), .HIGH_SIDE_ON(high_side));

    // --------------------------------------------------------------
    // verdict and hang guard
    // --------------------------------------------------------------
    task automatic stop_test;
        $display("compares %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // cycle counter; a run past the ceiling is a hang
    always @(posedge CLOCK) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            stop_test();
        end
    end

    // --------------------------------------------------------------
    // read monitor: data lands one edge after the read strobe
    // --------------------------------------------------------------
    always @(posedge CLOCK) rd_d <= reg_rd;
    always @(negedge CLOCK) begin
        if (rd_d === 1'b1) begin
            e = exp_q.pop_front();
            `CHK("read data", e, reg_rdata);
        end
    end

    // note the expected byte, then issue the read
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        host.rd(a);
    endtask

    // switch drive must hold one level over a whole period and more
    task automatic hs_hold(input logic x);
        repeat (2) @(negedge CLOCK);
        repeat (130) begin
            @(negedge CLOCK);
            `CHK("high side", x, high_side);
        end
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        dummy = $urandom(32'hE7E4);
        RST = 1'b1;
        pin = 1'b1;
        pg_raw = 1'b1;
        light = 1'b0;
        duty = 7'h00;
        repeat (5) @(negedge CLOCK);
        RST = 1'b0;
        // reset image of the bank and an unmapped address
        rd_chk(8'h30, 8'h40);
        rd_chk(8'h31, 8'h00);
        rd_chk(8'h32, 8'h00);
        rd_chk(8'h33, 8'h03);
        rd_chk(8'h34, 8'h00);
        `CHK("reset target mv", 13'h4E2, target_mv);
        `CHK("reset unavailable", 1'b0, unavail);
        // high range: random codes, top bit written high but read low
        for (i = 0; i < 8; i++) begin
            code = (i == 0) ? 6'h3F : 6'($urandom);
            host.wr(8'h30, {2'b11, code});
            @(negedge CLOCK);
            `CHK("target mv", 13'(13'h4E2 + 13'h32 * code), target_mv);
            `CHK("voltage code", code, vcode);
            `CHK("range select", 1'b1, rsel);
            `CHK("unavailable", 1'b0, unavail);
            rd_chk(8'h30, {2'b01, code});
        end
        // low range: first code, a middle one and the last
        foreach (lo_code[k]) begin
            host.wr(8'h30, {2'b00, lo_code[k]});
            @(negedge CLOCK);
            `CHK("low target mv", lo_mv[k], target_mv);
            `CHK("low range select", 1'b0, rsel);
            `CHK("low unavailable", 1'b0, unavail);
        end
        rd_chk(8'h30, 8'h3F);
        // mode bit and read-only places
        host.wr(8'h31, 8'hFF);
        host.wr(8'h32, 8'hFF);
        rd_chk(8'h31, 8'h01);
        rd_chk(8'h32, 8'h00);
        `CHK("forced fixed", 1'b1, force_ff);
        // enable: pin and bit in all four combinations
        for (i = 0; i < 4; i++) begin
            host.wr(8'h33, {7'h7F, i[1]});
            pin = i[0];
            repeat (2) @(negedge CLOCK);
            `CHK("run", i[0] & i[1], run);
        end
        rd_chk(8'h33, 8'h03);
        // power-good low, then a rise that the read path must lag
        pg_raw = 1'b0;
        repeat (3) @(negedge CLOCK);
        rd_chk(8'h33, 8'h01);
        pg_raw = 1'b1;
        rd_chk(8'h33, 8'h01);
        rd_chk(8'h33, 8'h03);
        // oscillator period between ticks
        t0 = 0;
        for (i = 0; i < 300; i++) begin
            @(negedge CLOCK);
            if (osc_tick === 1'b1 && t0 != 0) `CHK("osc period", 625 / 5, cyc - t0);
            if (osc_tick === 1'b1) t0 = cyc;
        end
        // partial duty: on cycles per period follow the demand
        duty = 7'h10;
        repeat (2) @(negedge CLOCK);
        n = 0;
        repeat (125) begin
            @(negedge CLOCK);
            if (high_side === 1'b1) n++;
        end
        `CHK("on cycles", 16, n);
        // full duty at light load under forced fixed frequency
        duty = 7'h7F;
        light = 1'b1;
        hs_hold(1'b1);
        // saving mode allowed: light load stops switching
        host.wr(8'h31, 8'h00);
        hs_hold(1'b0);
        // reset in mid-run must bring back the reset image
        RST = 1'b1;
        repeat (2) @(negedge CLOCK);
        RST = 1'b0;
        rd_chk(8'h30, 8'h40);
        rd_chk(8'h31, 8'h00);
        rd_chk(8'h33, 8'h03);
        `CHK("run after reset", 1'b1, run);
        repeat (3) @(negedge CLOCK);
        stop_test();
    end
endmodule
